// >>> rtl/tpwc_pkg.sv
// Package for the pulse-width capture timer channel: register map, fields, reset values.
// Assumes a single peripheral clock and a plain one-cycle register port.
package tpwc_pkg;
  localparam int TPWC_AW = 4;
  localparam logic [3:0] TPWC_A_CTL0 = 4'h0;
  localparam logic [3:0] TPWC_A_CTL1 = 4'h1;
  localparam logic [3:0] TPWC_A_OUTC = 4'h2;
  localparam logic [3:0] TPWC_A_CAPE = 4'h3;
  localparam logic [3:0] TPWC_A_EVTE = 4'h4;
  localparam logic [3:0] TPWC_A_OPT = 4'h5;
  localparam logic [3:0] TPWC_A_CNT = 4'h6;
  localparam logic [3:0] TPWC_A_CAP0 = 4'h7;
  localparam logic [3:0] TPWC_A_CAP1 = 4'h8;
  localparam logic [3:0] TPWC_A_SEL = 4'h9;
  localparam logic [3:0] TPWC_A_OVFCLR = 4'ha;
  localparam int TPWC_RUN_BIT = 7;
  localparam int TPWC_EEE_BIT = 5;
  localparam int TPWC_OVF_BIT = 0;
  localparam int TPWC_SEL0_BIT = 3;
  localparam int TPWC_SEL1_BIT = 4;
  localparam logic [2:0] TPWC_MODE_PWM = 3'h6;
  localparam logic [2:0] TPWC_MODE_IVL = 3'h0;
  localparam logic [2:0] TPWC_MODE_EXT = 3'h1;
  localparam logic [2:0] TPWC_MODE_FREE = 3'h5;
  localparam logic [7:0] TPWC_RST8 = 8'h00;
  localparam logic [7:0] TPWC_SEL_MASK = 8'h18;
  localparam logic [15:0] TPWC_CNT_ZERO = 16'h0000;
  localparam logic [15:0] TPWC_CNT_MAX = 16'hffff;
  localparam logic [15:0] TPWC_RST16 = 16'h0000;
  localparam logic [15:0] TPWC_ONE16 = 16'h0001;
  localparam logic [1:0] TPWC_EDGE_NONE = 2'h0;
  localparam logic [1:0] TPWC_EDGE_RISE = 2'h1;
  localparam logic [1:0] TPWC_EDGE_FALL = 2'h2;
  localparam logic [1:0] TPWC_EDGE_BOTH = 2'h3;
  localparam int TPWC_PRE_W = 8;
endpackage : tpwc_pkg

// >>> rtl/tpwc_edge_if.sv
// Interface carrying capture strobes from the input stage to the timer core.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface tpwc_edge_if;
  logic [1:0] edge_sel0;
  logic [1:0] edge_sel1;
  logic [1:0] strobe;
  modport src (input edge_sel0, input edge_sel1, output strobe);
  modport dst (output edge_sel0, output edge_sel1, input strobe);
endinterface : tpwc_edge_if

// >>> rtl/tpwc_edge.sv
// Capture input stage: two-flop synchronisers and valid edge detection.
// Assumes asynchronous pin inputs and sys_clk as the only clock.
`timescale 1ns/1ps
module tpwc_edge
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [1:0] pin_in,
  tpwc_edge_if.src eif
);
  import tpwc_pkg::*;
  logic [1:0] meta_q;
  logic [1:0] sync_q;
  logic [1:0] last_q;
  logic [1:0] strobe_q;
  logic [1:0] sel [2];
  assign sel[0] = eif.edge_sel0;
  assign sel[1] = eif.edge_sel1;
  assign eif.strobe = strobe_q;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_q <= 2'h0;
      sync_q <= 2'h0;
      last_q <= 2'h0;
    end
    else
    begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 2; i++)
    begin : g_ch
      logic rise;
      logic fall;
      assign rise = sync_q[i] & ~last_q[i];
      assign fall = ~sync_q[i] & last_q[i];
      always_ff @(posedge sys_clk or negedge resetn)
      begin
        if (!resetn)
          strobe_q[i] <= 1'b0;
        else
          case (sel[i])
            TPWC_EDGE_RISE: strobe_q[i] <= rise;
            TPWC_EDGE_FALL: strobe_q[i] <= fall;
            TPWC_EDGE_BOTH: strobe_q[i] <= rise | fall;
            default: strobe_q[i] <= 1'b0;
          endcase
      end
      strobe_single_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        strobe_q[i] |=> !strobe_q[i]) else $error("capture strobe longer than one cycle");
    end
  endgenerate
endmodule : tpwc_edge

// >>> rtl/tpwc_top.sv
// Top of the pulse-width capture timer channel with register port and pin outputs.
// Assumes register strobes and pins as described; capture pins and receive pins are asynchronous.
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
// Operation
// - Mode field 110 selects pulse-width measurement.
// - Counter runs only while run enable is 1.
// - Counts internal prescaled clock, external event deselected.
// - Valid edge captures count, clears counter, interrupts.
// - Overflow past FFFFH: interrupt, flag, wrap, continue.
// - Flag cleared by bit clear or byte write.
// - Set beats clear in same cycle.
// - Counter readback returns count without disturbance.
// - Idle level 0: low idle, high running.
// - Idle level 1: high idle, low running.
// - Output pins act per mode, none here.
// - Output control ignored in pulse-width mode.
// - Channel one capture source pin or receive.
// - Selector bits 3 and 4 route receive pins.
module tpwc_top
#(
  parameter int PRE_W = tpwc_pkg::TPWC_PRE_W
)
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [tpwc_pkg::TPWC_AW-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [1:0] capture_input_pin,
  input wire logic serial_receive_pin_0,
  input wire logic serial_receive_pin_1,
  output logic [1:0] timer_output_pin,
  output logic [1:0] capture_match_interrupt,
  output logic counter_overflow_interrupt
);
  import tpwc_pkg::*;

  logic [7:0] ctl0_q;
  logic [7:0] ctl1_q;
  logic [7:0] outc_q;
  logic [7:0] cape_q;
  logic [7:0] evte_q;
  logic [7:0] opt_q;
  logic [7:0] sel_q;
  logic [15:0] cnt_q;
  logic [15:0] cap_q [2];
  logic ovf_q;
  logic [PRE_W-1:0] pre_q;
  logic [15:0] rdata_q;
  logic [1:0] ccint_q;
  logic ovint_q;
  logic [1:0] tout_q;
  logic [1:0] tgl_q;
  logic run;
  logic pwm_mode;
  logic tick;
  logic [1:0] cap_src;
  logic [1:0] cap_stb;
  logic ovf_evt;
  logic ovf_clr;
  logic [2:0] mode;
  logic [2:0] cks;
  tpwc_edge_if eif ();

  assign run = ctl0_q[TPWC_RUN_BIT];
  assign cks = ctl0_q[2:0];
  assign mode = ctl1_q[2:0];
  assign pwm_mode = (mode == TPWC_MODE_PWM);
  // Selection routes receive lines ahead of the synchronisers, so a switch may cause one spurious edge.
  assign cap_src[0] = sel_q[TPWC_SEL0_BIT] ? serial_receive_pin_0 : capture_input_pin[0];
  assign cap_src[1] = sel_q[TPWC_SEL1_BIT] ? serial_receive_pin_1 : capture_input_pin[1];
  assign eif.edge_sel0 = cape_q[1:0];
  assign eif.edge_sel1 = cape_q[3:2];
  assign cap_stb = (pwm_mode && run) ? eif.strobe : 2'h0;

  tpwc_edge u_edge
  (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .pin_in(cap_src),
    .eif(eif)
  );

  // Prescaler tap: count clock is sys_clk divided by two to the power of the select field.
  always_comb
  begin
    tick = 1'b0;
    if (cks == 3'h0)
      tick = 1'b1;
    else
      tick = (pre_q[cks-3'h1 +: 1] == 1'b1) && (pre_q & ((PRE_W'(1) << cks) - PRE_W'(1))) ==
             ((PRE_W'(1) << cks) - PRE_W'(1));
    tick = tick && !ctl1_q[TPWC_EEE_BIT];
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      pre_q <= '0;
    else if (!run)
      pre_q <= '0;
    else
      pre_q <= pre_q + PRE_W'(1);
  end

  assign ovf_evt = pwm_mode && run && tick && (cnt_q == TPWC_CNT_MAX) && (cap_stb == 2'h0);
  assign ovf_clr = reg_wr && ((reg_addr == TPWC_A_OPT && !reg_wdata[TPWC_OVF_BIT]) ||
                   (reg_addr == TPWC_A_OVFCLR && reg_wdata[TPWC_OVF_BIT]));

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      cnt_q <= TPWC_CNT_ZERO;
    else if (!run)
      cnt_q <= TPWC_CNT_ZERO;
    else if (pwm_mode && cap_stb != 2'h0)
      cnt_q <= TPWC_CNT_ZERO;
    else if (tick)
      cnt_q <= cnt_q + TPWC_ONE16;
  end

  genvar m;
  generate
    for (m = 0; m < 2; m++)
    begin : g_cap
      always_ff @(posedge sys_clk or negedge resetn)
      begin
        if (!resetn)
          cap_q[m] <= TPWC_RST16;
        else if (cap_stb[m])
          cap_q[m] <= cnt_q;
        else if (reg_wr && reg_addr == (m == 0 ? TPWC_A_CAP0 : TPWC_A_CAP1))
          cap_q[m] <= reg_wdata;
      end
      always_ff @(posedge sys_clk or negedge resetn)
      begin
        if (!resetn)
          ccint_q[m] <= 1'b0;
        else
          ccint_q[m] <= cap_stb[m];
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      ovf_q <= 1'b0;
    else if (ovf_evt)
      ovf_q <= 1'b1;
    else if (ovf_clr)
      ovf_q <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      ovint_q <= 1'b0;
    else
      ovint_q <= ovf_evt;
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctl0_q <= TPWC_RST8;
      ctl1_q <= TPWC_RST8;
      outc_q <= TPWC_RST8;
      cape_q <= TPWC_RST8;
      evte_q <= TPWC_RST8;
      opt_q <= TPWC_RST8;
      sel_q <= TPWC_RST8;
    end
    else if (reg_wr)
      case (reg_addr)
        TPWC_A_CTL0: ctl0_q <= reg_wdata[7:0];
        TPWC_A_CTL1: ctl1_q <= reg_wdata[7:0];
        TPWC_A_OUTC: outc_q <= reg_wdata[7:0];
        TPWC_A_CAPE: cape_q <= reg_wdata[7:0];
        TPWC_A_EVTE: evte_q <= reg_wdata[7:0];
        TPWC_A_OPT: opt_q <= {reg_wdata[7:1], 1'b0};
        TPWC_A_SEL: sel_q <= reg_wdata[7:0] & TPWC_SEL_MASK;
        default: ;
      endcase
  end

  // Square-wave toggles on wrap in interval and external-event modes only; pulse-width and free-running modes never toggle.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      tgl_q <= 2'h0;
    else if (!run)
      tgl_q <= 2'h0;
    else if (tick && cnt_q == TPWC_CNT_MAX && (mode == TPWC_MODE_IVL || mode == TPWC_MODE_EXT))
      tgl_q <= ~tgl_q;
  end

  generate
    for (m = 0; m < 2; m++)
    begin : g_out
      logic lvl;
      logic oen;
      assign lvl = outc_q[2*m+1];
      assign oen = outc_q[2*m];
      always_ff @(posedge sys_clk or negedge resetn)
      begin
        if (!resetn)
          tout_q[m] <= 1'b0;
        else if (pwm_mode)
          tout_q[m] <= 1'b0;
        else if (!oen || !run)
          tout_q[m] <= lvl;
        else
          tout_q[m] <= ~lvl ^ tgl_q[m];
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      rdata_q <= TPWC_RST16;
    else if (reg_rd)
      case (reg_addr)
        TPWC_A_CTL0: rdata_q <= {8'h00, ctl0_q};
        TPWC_A_CTL1: rdata_q <= {8'h00, ctl1_q};
        TPWC_A_OUTC: rdata_q <= {8'h00, outc_q};
        TPWC_A_CAPE: rdata_q <= {8'h00, cape_q};
        TPWC_A_EVTE: rdata_q <= {8'h00, evte_q};
        TPWC_A_OPT: rdata_q <= {8'h00, opt_q[7:1], ovf_q};
        TPWC_A_CNT: rdata_q <= cnt_q;
        TPWC_A_CAP0: rdata_q <= cap_q[0];
        TPWC_A_CAP1: rdata_q <= cap_q[1];
        TPWC_A_SEL: rdata_q <= {8'h00, sel_q};
        default: rdata_q <= TPWC_RST16;
      endcase
    else
      rdata_q <= TPWC_RST16;
  end

  assign reg_rdata = rdata_q;
  assign capture_match_interrupt = ccint_q;
  assign counter_overflow_interrupt = ovint_q;
  assign timer_output_pin = tout_q;

  stop_holds_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !run |=> cnt_q == TPWC_CNT_ZERO) else $error("counter moved while stopped");
  capture_value_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    cap_stb[0] |=> cap_q[0] == $past(cnt_q) && cnt_q == TPWC_CNT_ZERO && ccint_q[0])
    else $error("capture did not store and clear");
  overflow_wrap_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    ovf_evt |=> ovf_q && ovint_q && cnt_q == TPWC_CNT_ZERO) else $error("overflow not handled");
  set_wins_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    ovf_evt && ovf_clr |=> ovf_q) else $error("clear beat overflow set");
  flag_clear_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    ovf_clr && !ovf_evt |=> !ovf_q) else $error("overflow flag not cleared");
  readback_cnt_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_rd && reg_addr == TPWC_A_CNT |=> reg_rdata == $past(cnt_q)) else $error("bad count readback");
  pwm_quiet_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    pwm_mode ##1 pwm_mode |-> timer_output_pin == 2'h0) else $error("output active in capture mode");
  idle_level_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !pwm_mode && !outc_q[0] ##1 $stable(outc_q) |-> timer_output_pin[0] == outc_q[1])
    else $error("idle level wrong");
endmodule : tpwc_top

// >>> dv/tpwc_pin_model.sv
// Pin model for the far side: two capture pins and two receive lines.
// Assumes sys_clk from the bench; capture pins idle low, receive lines idle high.
`timescale 1ns/1ps
module tpwc_pin_model
(
  input wire logic sys_clk,
  output logic [1:0] cap_pin,
  output logic rx0,
  output logic rx1
);
  localparam logic [3:0] IDLE_LVL = 4'hc;
  logic [3:0] line_q = 4'hc;
  assign cap_pin = line_q[1:0];
  assign rx0 = line_q[2];
  assign rx1 = line_q[3];
  // One pulse away from idle; lines change only after an edge, as a real pin would relative to the sampler.
  task automatic pulse(input int which, input int hi, input int lo);
    @(posedge sys_clk);
    line_q[which] <= ~IDLE_LVL[which];
    repeat (hi) @(posedge sys_clk);
    line_q[which] <= IDLE_LVL[which];
    repeat (lo) @(posedge sys_clk);
  endtask : pulse
endmodule : tpwc_pin_model

// >>> dv/timer_pulse_width_capture_test.sv
// Self-checking bench for the pulse-width capture timer channel.
// Assumes the pin model in dv and the register map of the package.
`timescale 1ns/1ps
`define CHK(g, x) begin checks++; if ((g) !== (x)) begin err_count++; $display("CHECK FAILED at %0t: got %h want %h", $time, g, x); end end
module timer_pulse_width_capture_test;
  import tpwc_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [1:0] cap_pin;
  logic rx0;
  logic rx1;
  logic [1:0] tout;
  logic [1:0] cap_irq;
  logic ovf_irq;
  wire [2:0] irq_v = {ovf_irq, cap_irq};
  int err_count = 0;
  int checks = 0;
  logic [15:0] v [4];
  logic [15:0] d;
  logic [15:0] e;
  bit h;
  always #4 sys_clk = ~sys_clk;
  tpwc_pin_model pm_u (.sys_clk(sys_clk), .cap_pin(cap_pin), .rx0(rx0), .rx1(rx1));
  tpwc_top dut_u
  (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .capture_input_pin(cap_pin),
    .serial_receive_pin_0(rx0),
    .serial_receive_pin_1(rx1),
    .timer_output_pin(tout),
    .capture_match_interrupt(cap_irq),
    .counter_overflow_interrupt(ovf_irq)
  );
  task automatic wr(input logic [3:0] a, input logic [15:0] w);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= w;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] r);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    r = reg_rdata;
  endtask : rd
  // Interrupts are one-cycle pulses, so every cycle is looked at.
  task automatic wait_irq(input int which, input int lim, output bit hit);
    hit = 1'b0;
    for (int i = 0; i < lim && !hit; i++)
    begin
      @(negedge sys_clk);
      hit = (irq_v[which] === 1'b1);
    end
  endtask : wait_irq
  task automatic t_reset();
    rd(TPWC_A_CTL0, d);
    `CHK(d, 16'h0000)
    rd(TPWC_A_SEL, d);
    `CHK(d, 16'h0000)
    rd(4'hb, d);
    `CHK(d, 16'h0000)
    rd(TPWC_A_CNT, d);
    `CHK(d, 16'h0000)
  endtask : t_reset
  task automatic t_capture();
    wr(TPWC_A_CAPE, 16'h0001);
    wr(TPWC_A_CTL1, {13'h0000, TPWC_MODE_PWM});
    wr(TPWC_A_OUTC, 16'h000f);
    wr(TPWC_A_CTL0, 16'h0080);
    rd(TPWC_A_CNT, d);
    rd(TPWC_A_CNT, e);
    `CHK(e - d, 16'h0002)
    `CHK(tout, 2'b00)
    fork
      begin
        pm_u.pulse(0, 4, 40);
        pm_u.pulse(0, 4, 40);
        pm_u.pulse(0, 4, 60);
        pm_u.pulse(0, 4, 10);
      end
      for (int k = 0; k < 4; k++)
      begin
        wait_irq(0, 80, h);
        `CHK(h, 1'b1)
        rd(TPWC_A_CAP0, v[k]);
      end
    join
    `CHK(v[2], v[1])
    `CHK(v[1], 16'h002c)
    `CHK(v[3] - v[1], 16'h0014)
    wr(TPWC_A_CTL0, 16'h0081);
    rd(TPWC_A_CNT, d);
    rd(TPWC_A_CNT, e);
    `CHK(e - d, 16'h0001)
  endtask : t_capture
  task automatic t_select();
    wr(TPWC_A_CTL0, 16'h0000);
    wr(TPWC_A_SEL, 16'h00ff);
    rd(TPWC_A_SEL, d);
    `CHK(d, 16'h0018)
    wr(TPWC_A_CAPE, 16'h0008);
    wr(TPWC_A_CTL0, 16'h0080);
    fork
      pm_u.pulse(1, 4, 20);
      wait_irq(1, 25, h);
    join
    `CHK(h, 1'b0)
    fork
      pm_u.pulse(3, 4, 20);
      wait_irq(1, 25, h);
    join
    `CHK(h, 1'b1)
  endtask : t_select
  task automatic t_output();
    wr(TPWC_A_CTL0, 16'h0000);
    wr(TPWC_A_SEL, 16'h0000);
    wr(TPWC_A_CAPE, 16'h0000);
    wr(TPWC_A_CTL1, {13'h0000, TPWC_MODE_IVL});
    wr(TPWC_A_OUTC, 16'h000a);
    repeat (2) @(negedge sys_clk);
    `CHK(tout, 2'b11)
    wr(TPWC_A_OUTC, 16'h0005);
    repeat (2) @(negedge sys_clk);
    `CHK(tout, 2'b00)
    wr(TPWC_A_CTL0, 16'h0080);
    repeat (2) @(negedge sys_clk);
    `CHK(tout, 2'b11)
    wr(TPWC_A_OUTC, 16'h000f);
    repeat (2) @(negedge sys_clk);
    `CHK(tout, 2'b00)
  endtask : t_output
  task automatic t_overflow();
    wr(TPWC_A_CTL0, 16'h0000);
    wr(TPWC_A_CTL1, {13'h0000, TPWC_MODE_PWM});
    wr(TPWC_A_CTL0, 16'h0080);
    wait_irq(2, 70000, h);
    `CHK(h, 1'b1)
    rd(TPWC_A_CNT, d);
    `CHK(d[15:4], 12'h000)
    rd(TPWC_A_OPT, d);
    `CHK(d, 16'h0001)
    wr(TPWC_A_OPT, 16'h0001);
    rd(TPWC_A_OPT, d);
    `CHK(d, 16'h0001)
    wr(TPWC_A_OVFCLR, 16'h0001);
    rd(TPWC_A_OPT, d);
    `CHK(d, 16'h0000)
  endtask : t_overflow
  task automatic conclude();
    $display("mismatches %0d of %0d comparisons", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  initial
  begin
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset();
    t_capture();
    t_select();
    t_output();
    t_overflow();
    conclude();
  end
  // The overflow wait dominates the run, so the limit sits just above one full counter cycle.
  initial
  begin
    repeat (80000) @(posedge sys_clk);
    err_count++;
    conclude();
  end
endmodule : timer_pulse_width_capture_test
